// ### include/sps_pkg.sv
// constants and carrier types for the serial port status block
package sps_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] SPS_STATUS_OFS = 8'h94;
  localparam logic [7:0] SPS_CTRL_OFS = 8'h98;
  localparam logic [7:0] SPS_IRQ_STAT_OFS = 8'h9c;
  localparam logic [7:0] SPS_IRQ_MASK_OFS = 8'ha0;

  // ------------------------------------------------------------
  // status field positions
  // ------------------------------------------------------------
  localparam int SPS_SLEW_BIT = 7;
  localparam int SPS_SMBUS_BIT = 6;
  localparam int SPS_DATA_ADDR_BIT = 5;
  localparam int SPS_STOP_BIT = 4;
  localparam int SPS_START_BIT = 3;
  localparam int SPS_DIR_BIT = 2;
  localparam int SPS_RELOAD_BIT = 1;
  localparam int SPS_BUF_FULL_BIT = 0;

  // ------------------------------------------------------------
  // control and interrupt field positions
  // ------------------------------------------------------------
  localparam int SPS_CTRL_EN_BIT = 0;
  localparam int SPS_CTRL_MASTER_BIT = 1;
  localparam int SPS_CTRL_TENBIT_BIT = 2;
  localparam int SPS_IRQ_START_BIT = 0;
  localparam int SPS_IRQ_STOP_BIT = 1;
  localparam int SPS_IRQ_BYTE_BIT = 2;
  localparam int SPS_IRQ_MATCH_BIT = 3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] SPS_STATUS_RST = 8'h00;
  localparam logic [2:0] SPS_CTRL_RST = 3'h0;
  localparam logic [3:0] SPS_IRQ_RST = 4'h0;

  // ------------------------------------------------------------
  // carrier types
  // ------------------------------------------------------------
  // same-clock strobes and levels from the serial engine
  typedef struct packed {
    logic addr_match;
    logic rw_bit;
    logic byte_done;
    logic byte_is_data;
    logic rx_done;
    logic buf_read;
    logic tx_load;
    logic tx_done;
    logic reload_set;
    logic reload_clr;
    logic tx_busy;
  } sps_engine_type;

  // master sequence request bits
  typedef struct packed {
    logic start_request;
    logic repeated_start_request;
    logic stop_request;
    logic receive_request;
    logic ack_sequence_request;
  } sps_req_type;

  // whole state of the block
  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic [7:0] status;
    logic [2:0] ctrl;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
  } sps_state_type;

endpackage

// ### src/sps_status_reg.sv
// status and configuration register of the two-wire serial port
`timescale 1ns/1ps

module sps_status_reg (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // raw bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  // serial engine side
  input wire sps_pkg::sps_engine_type eng_i,
  input wire sps_pkg::sps_req_type req_i,
  // configuration and status outward
  output logic slew_limit_en_o,
  output logic smbus_levels_o,
  output logic port_enable_o,
  output logic master_mode_o,
  output logic ten_bit_mode_o,
  output logic idle_o,
  output logic [7:0] status_o,
  // interrupt
  output logic irq_o
);

  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  sps_pkg::sps_state_type st_reg;
  sps_pkg::sps_state_type st_next;
  logic req_take;
  logic wr_byte;
  logic sel_status;
  logic sel_ctrl;
  logic sel_istat;
  logic sel_imask;
  logic en;
  logic master;
  logic start_det;
  logic stop_det;
  logic [3:0] irq_evt;
  logic [31:0] rd_word;

  // ------------------------------------------------------------
  // decode and bus condition detect
  // ------------------------------------------------------------
  // a new request is taken once; ack blocks a second take
  assign req_take = wb_cyc_i & wb_stb_i & ~st_reg.ack;
  assign wr_byte = req_take & wb_we_i & wb_sel_i[0];
  assign sel_status = wb_adr_i[7:2] == sps_pkg::SPS_STATUS_OFS[7:2];
  assign sel_ctrl = wb_adr_i[7:2] == sps_pkg::SPS_CTRL_OFS[7:2];
  assign sel_istat = wb_adr_i[7:2] == sps_pkg::SPS_IRQ_STAT_OFS[7:2];
  assign sel_imask = wb_adr_i[7:2] == sps_pkg::SPS_IRQ_MASK_OFS[7:2];
  assign en = st_reg.ctrl[sps_pkg::SPS_CTRL_EN_BIT];
  assign master = st_reg.ctrl[sps_pkg::SPS_CTRL_MASTER_BIT];

  // start and stop edges
  // sda falls (start) or rises (stop) while scl stays high; only second sync stage is used
  assign start_det = en & st_reg.scl_sync[1] & st_reg.scl_prev
                     & st_reg.sda_prev & ~st_reg.sda_sync[1];
  assign stop_det = en & st_reg.scl_sync[1] & st_reg.scl_prev
                    & ~st_reg.sda_prev & st_reg.sda_sync[1];

  // interrupt sources
  assign irq_evt[sps_pkg::SPS_IRQ_START_BIT] = start_det;
  assign irq_evt[sps_pkg::SPS_IRQ_STOP_BIT] = stop_det;
  assign irq_evt[sps_pkg::SPS_IRQ_BYTE_BIT] = en & (eng_i.rx_done | eng_i.tx_done);
  assign irq_evt[sps_pkg::SPS_IRQ_MATCH_BIT] = en & eng_i.addr_match;

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  // unmapped words read zero and still answer
  always_comb begin
    rd_word = 32'h0000_0000;
    if (sel_status) begin
      rd_word[7:0] = st_reg.status;
    end else if (sel_ctrl) begin
      rd_word[2:0] = st_reg.ctrl;
    end else if (sel_istat) begin
      rd_word[3:0] = st_reg.irq_stat;
    end else if (sel_imask) begin
      rd_word[3:0] = st_reg.irq_mask;
    end
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    // pin synchronisers, then one stage of history
    st_next.scl_sync = {st_reg.scl_sync[0], scl_i};
    st_next.sda_sync = {st_reg.sda_sync[0], sda_i};
    st_next.scl_prev = st_reg.scl_sync[1];
    st_next.sda_prev = st_reg.sda_sync[1];
    // answer one cycle after the take, dropped the cycle after
    st_next.ack = req_take;
    if (req_take) begin
      st_next.rdata = rd_word;
    end
    // software writes
    if (wr_byte && sel_status) begin
      st_next.status[sps_pkg::SPS_SLEW_BIT] = wb_dat_i[sps_pkg::SPS_SLEW_BIT];
      st_next.status[sps_pkg::SPS_SMBUS_BIT] = wb_dat_i[sps_pkg::SPS_SMBUS_BIT];
    end
    if (wr_byte && sel_ctrl) begin
      st_next.ctrl = wb_dat_i[2:0];
    end
    if (wr_byte && sel_imask) begin
      st_next.irq_mask = wb_dat_i[3:0];
    end
    if (start_det) begin
      st_next.status[sps_pkg::SPS_START_BIT] = 1'b1;
      st_next.status[sps_pkg::SPS_STOP_BIT] = 1'b0;
    end
    if (stop_det) begin
      st_next.status[sps_pkg::SPS_STOP_BIT] = 1'b1;
      st_next.status[sps_pkg::SPS_START_BIT] = 1'b0;
    end
    if (!en) begin
      st_next.status[sps_pkg::SPS_START_BIT] = 1'b0;
      st_next.status[sps_pkg::SPS_STOP_BIT] = 1'b0;
    end
    if (master) begin
      st_next.status[sps_pkg::SPS_DATA_ADDR_BIT] = 1'b0;
    end else if (eng_i.byte_done) begin
      st_next.status[sps_pkg::SPS_DATA_ADDR_BIT] = eng_i.byte_is_data;
    end
    if (master) begin
      st_next.status[sps_pkg::SPS_DIR_BIT] = eng_i.tx_busy;
    end else if (eng_i.addr_match) begin
      st_next.status[sps_pkg::SPS_DIR_BIT] = eng_i.rw_bit;
    end
    if (!st_reg.ctrl[sps_pkg::SPS_CTRL_TENBIT_BIT]) begin
      st_next.status[sps_pkg::SPS_RELOAD_BIT] = 1'b0;
    end else if (eng_i.reload_set) begin
      st_next.status[sps_pkg::SPS_RELOAD_BIT] = 1'b1;
    end else if (eng_i.reload_clr) begin
      st_next.status[sps_pkg::SPS_RELOAD_BIT] = 1'b0;
    end
    if (eng_i.rx_done || eng_i.tx_load) begin
      st_next.status[sps_pkg::SPS_BUF_FULL_BIT] = 1'b1;
    end else if (eng_i.buf_read || eng_i.tx_done) begin
      st_next.status[sps_pkg::SPS_BUF_FULL_BIT] = 1'b0;
    end
    // sticky events; a read clears, a same-cycle event survives
    if (req_take && !wb_we_i && sel_istat) begin
      st_next.irq_stat = irq_evt;
    end else begin
      st_next.irq_stat = st_reg.irq_stat | irq_evt;
    end
    if (rst_i) begin
      st_next = '0;
      st_next.status = sps_pkg::SPS_STATUS_RST;
      st_next.ctrl = sps_pkg::SPS_CTRL_RST;
      st_next.irq_stat = sps_pkg::SPS_IRQ_RST;
      st_next.irq_mask = sps_pkg::SPS_IRQ_RST;
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    st_reg <= st_next;
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign wb_dat_o = st_reg.rdata;
  assign wb_ack_o = st_reg.ack;
  assign slew_limit_en_o = ~st_reg.status[sps_pkg::SPS_SLEW_BIT];
  assign smbus_levels_o = st_reg.status[sps_pkg::SPS_SMBUS_BIT];
  assign port_enable_o = en;
  assign master_mode_o = master;
  assign ten_bit_mode_o = st_reg.ctrl[sps_pkg::SPS_CTRL_TENBIT_BIT];
  // idle when nothing pending
  // request bits are live, so idle drops the cycle one is raised
  assign idle_o = ~((master & st_reg.status[sps_pkg::SPS_DIR_BIT]) | (|req_i));
  assign status_o = st_reg.status;
  assign irq_o = |(st_reg.irq_stat & st_reg.irq_mask);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  property p_start_flag;
    start_det && !stop_det |=> status_o[3] && !status_o[4];
  endproperty
  a_start_flag: assert property (p_start_flag)
    else $error("start flag not set after start");

  property p_stop_flag;
    stop_det |=> status_o[4] && !status_o[3];
  endproperty
  a_stop_flag: assert property (p_stop_flag)
    else $error("stop flag not set after stop");

  property p_disable_clears;
    !port_enable_o |=> !status_o[4] && !status_o[3];
  endproperty
  a_disable_clears: assert property (p_disable_clears)
    else $error("bus flags survive a disabled port");

  property p_slave_dir;
    !master_mode_o && eng_i.addr_match |=> status_o[2] == $past(eng_i.rw_bit);
  endproperty
  a_slave_dir: assert property (p_slave_dir)
    else $error("slave direction missed address rw bit");

  property p_master_dir;
    master_mode_o && eng_i.tx_busy ##1 master_mode_o |-> !idle_o;
  endproperty
  a_master_dir: assert property (p_master_dir)
    else $error("master busy but port reads idle");

  property p_idle;
    idle_o |-> !(|req_i) && !(master_mode_o && status_o[2]);
  endproperty
  a_idle: assert property (p_idle)
    else $error("idle while request pending");

  property p_data_addr;
    !master_mode_o && eng_i.byte_done |=> status_o[5] == $past(eng_i.byte_is_data);
  endproperty
  a_data_addr: assert property (p_data_addr)
    else $error("data/address flag wrong");

  property p_rx_full;
    eng_i.rx_done |=> status_o[0];
  endproperty
  a_rx_full: assert property (p_rx_full)
    else $error("buffer full not set after receive");

  property p_tx_empty;
    eng_i.tx_done && !eng_i.tx_load && !eng_i.rx_done |=> !status_o[0];
  endproperty
  a_tx_empty: assert property (p_tx_empty)
    else $error("buffer full stuck after transmit");

  property p_reload;
    ten_bit_mode_o && eng_i.reload_set |=> status_o[1];
  endproperty
  a_reload: assert property (p_reload)
    else $error("reload flag not raised");

  property p_slew_write;
    wr_byte && sel_status |=> slew_limit_en_o == !$past(wb_dat_i[7]);
  endproperty
  a_slew_write: assert property (p_slew_write)
    else $error("slew limit does not follow write");

  property p_smbus_write;
    wr_byte && sel_status |=> smbus_levels_o == $past(wb_dat_i[6]);
  endproperty
  a_smbus_write: assert property (p_smbus_write)
    else $error("smbus levels do not follow write");

  property p_ro_ignored;
    wr_byte && sel_status && !master_mode_o && port_enable_o && eng_i == '0
      && !start_det && !stop_det && (ten_bit_mode_o || !status_o[1])
      |=> status_o[5:0] == $past(status_o[5:0]);
  endproperty
  a_ro_ignored: assert property (p_ro_ignored)
    else $error("read-only flag changed by write");

  property p_ack_one;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_one: assert property (p_ack_one)
    else $error("ack not a single cycle");

  property p_master_da;
    master_mode_o |=> !status_o[sps_pkg::SPS_DATA_ADDR_BIT];
  endproperty
  a_master_da: assert property (p_master_da)
    else $error("data/address flag not reserved in master mode");

  property p_reload_off;
    !ten_bit_mode_o |=> !status_o[sps_pkg::SPS_RELOAD_BIT];
  endproperty
  a_reload_off: assert property (p_reload_off)
    else $error("reload flag set outside ten-bit mode");

  property p_tx_full;
    eng_i.tx_load |=> status_o[sps_pkg::SPS_BUF_FULL_BIT];
  endproperty
  a_tx_full: assert property (p_tx_full)
    else $error("buffer full not set while byte is sent");

  property p_rx_read;
    eng_i.buf_read && !eng_i.rx_done && !eng_i.tx_load
      |=> !status_o[sps_pkg::SPS_BUF_FULL_BIT];
  endproperty
  a_rx_read: assert property (p_rx_read)
    else $error("buffer full stuck after buffer read");

  // an event in the cycle of a clearing read must survive
  property p_irq_sticky;
    irq_evt != 4'h0 |=> (st_reg.irq_stat & $past(irq_evt)) == $past(irq_evt);
  endproperty
  a_irq_sticky: assert property (p_irq_sticky)
    else $error("interrupt event lost");

  c_start: cover property (start_det ##[1:200] stop_det);
  c_slave_read: cover property (!master_mode_o && eng_i.addr_match && eng_i.rw_bit);
  c_irq: cover property (!irq_o ##1 irq_o);
  c_tx_byte: cover property (eng_i.tx_load ##[1:100] eng_i.tx_done);

endmodule // sps_status_reg

// ### verification/sps_bus_model.sv
// behavioural model of another device on the two-wire bus
`timescale 1ns/1ps
module sps_bus_model (
  // bus lines, both levels driven directly
  output logic scl_o,
  output logic sda_o
);
  // both lines idle high, clock stands still between frames
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // start then eight bits, data moves only while the clock is low
  task automatic frame(input logic [7:0] b);
    int i;
    sda_o <= 1'b0;
    #400;
    scl_o <= 1'b0;
    for (i = 7; i >= 0; i--) begin
      #200 sda_o <= b[i];
      #200 scl_o <= 1'b1;
      #400 scl_o <= 1'b0;
    end
  endtask

  // stop: data rises while the clock is high, then both rest high
  task automatic stop_cond;
    #200 sda_o <= 1'b0;
    #200 scl_o <= 1'b1;
    #400 sda_o <= 1'b1;
    #400;
  endtask
endmodule // sps_bus_model

// ### verification/tb.sv
// self-checking testbench for the serial port status register
`timescale 1ns/1ps
module tb;
  // stimulus and observed values
  logic clk_i, rst_i, cyc, stb, we, scl, sda;
  logic [7:0] adr, st, ex;
  logic [3:0] sel;
  logic [31:0] wdat, q, seed, v;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, slew_o, smb_o, en_o, mst_o, ten_o, idle_o, irq_o;
  logic [7:0] status_o;
  sps_pkg::sps_engine_type eng;
  sps_pkg::sps_req_type req;
  int n_errors, comparisons, k;

  sps_status_reg uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .scl_i(scl), .sda_i(sda), .eng_i(eng), .req_i(req),
    .slew_limit_en_o(slew_o), .smbus_levels_o(smb_o), .port_enable_o(en_o),
    .master_mode_o(mst_o), .ten_bit_mode_o(ten_o), .idle_o(idle_o), .status_o(status_o),
    .irq_o(irq_o));
  sps_bus_model bus (.scl_o(scl), .sda_o(sda));

  // 10 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // only the two config bits take data, and only with lane 0 selected
  function automatic logic [7:0] wr_exp(input logic [7:0] o, input logic [7:0] d, input logic s);
    return s ? {d[7:6], o[5:0]} : o;
  endfunction

  task automatic stop_test;
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask

  // classic single cycle, held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int i;
    i = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    do begin
      @(posedge clk_i);
      i++;
    end while (wb_ack_o !== 1'b1 && i < 20);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (i >= 20) begin
      n_errors++;
      stop_test;
    end
  endtask

  // one-cycle engine strobe, then let the status byte settle
  task automatic pulse(input logic [10:0] m);
    @(posedge clk_i);
    eng <= sps_pkg::sps_engine_type'(eng | m);
    @(posedge clk_i);
    eng <= sps_pkg::sps_engine_type'(eng & ~m);
    repeat (2) @(posedge clk_i);
    st = status_o;
  endtask

  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    eng = '0;
    req = '0;
    seed = 32'hff6c7904;
    n_errors = 0;
    comparisons = 0;
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    // every register comes up clear
    for (k = 0; k < 4; k++) begin
      wb(1'b0, 8'h94 + 8'(4 * k), 32'h0, 4'hf);
      chk("reset value", 32'h0, q);
    end
    chk("slew limit", 32'h1, slew_o);
    wb(1'b1, 8'h10, 32'hff, 4'hf);
    wb(1'b0, 8'h10, 32'h0, 4'hf);
    chk("unmapped read", 32'h0, q);
    // config bits by random writes, corners first
    ex = 8'h00;
    for (k = 0; k < 12; k++) begin
      seed = lfsr(seed);
      v = (k == 0) ? 32'hff : (k == 1) ? 32'h3f : seed;
      wb(1'b1, 8'h94, v, (k < 2) ? 4'hf : seed[11:8]);
      ex = wr_exp(ex, v[7:0], (k < 2) ? 1'b1 : seed[8]);
      wb(1'b0, 8'h94, 32'h0, 4'hf);
      chk("status byte", {24'h0, ex}, q);
      chk("slew limit", !ex[7], slew_o);
      chk("smbus levels", ex[6], smb_o);
    end
    // bus conditions seen by an enabled slave
    wb(1'b1, 8'ha0, 32'hf, 4'h1);
    wb(1'b1, 8'h98, 32'h1, 4'h1);
    chk("port enable", 32'h1, en_o);
    bus.frame(seed[7:0]);
    chk("start stop", 32'h1, status_o[4:3]);
    chk("irq line", 32'h1, irq_o);
    wb(1'b0, 8'h9c, 32'h0, 4'hf);
    chk("irq status", 32'h1, q);
    chk("irq line", 32'h0, irq_o);
    bus.stop_cond;
    chk("start stop", 32'h2, status_o[4:3]);
    wb(1'b0, 8'h9c, 32'h0, 4'hf);
    chk("irq status", 32'h2, q);
    // disabling clears both flags and blinds detection
    wb(1'b1, 8'h98, 32'h0, 4'h1);
    chk("port enable", 32'h0, en_o);
    repeat (2) @(posedge clk_i);
    chk("start stop", 32'h0, status_o[4:3]);
    bus.frame(8'h5a);
    chk("start stop", 32'h0, status_o[4:3]);
    bus.stop_cond;
    chk("start stop", 32'h0, status_o[4:3]);
    // slave direction and data/address
    wb(1'b1, 8'h98, 32'h1, 4'h1);
    for (k = 0; k < 8; k++) begin
      seed = lfsr(seed);
      pulse({1'b1, seed[0], 9'h0});
      chk("direction", seed[0], st[2]);
      pulse({2'b0, 1'b1, seed[1], 7'h0});
      chk("data address", seed[1], st[5]);
    end
    // buffer full on receive and transmit
    pulse(11'h040);
    chk("buffer full", 32'h1, st[0]);
    pulse(11'h020);
    chk("buffer full", 32'h0, st[0]);
    pulse(11'h010);
    chk("buffer full", 32'h1, st[0]);
    pulse(11'h008);
    chk("buffer full", 32'h0, st[0]);
    wb(1'b0, 8'h9c, 32'h0, 4'hf);
    chk("irq status", 32'hc, q);
    // reload request only in ten-bit mode, set wins over clear
    pulse(11'h004);
    chk("reload", 32'h0, st[1]);
    wb(1'b1, 8'h98, 32'h5, 4'h1);
    chk("ten bit mode", 32'h1, ten_o);
    pulse(11'h004);
    chk("reload", 32'h1, st[1]);
    pulse(11'h002);
    chk("reload", 32'h0, st[1]);
    pulse(11'h006);
    chk("reload", 32'h1, st[1]);
    // master: data/address reserved, direction tracks transmit, idle
    wb(1'b1, 8'h98, 32'h3, 4'h1);
    chk("master mode", 32'h1, mst_o);
    pulse(11'h180);
    chk("data address", 32'h0, st[5]);
    for (k = 0; k < 9; k++) begin
      seed = lfsr(seed);
      v = (k == 8) ? 32'h0 : seed;
      @(posedge clk_i);
      eng.tx_busy <= v[0];
      req <= v[5:1] & {5{v[6]}};
      repeat (3) @(posedge clk_i);
      chk("direction", v[0], status_o[2]);
      chk("idle", !(v[0] | (|(v[5:1] & {5{v[6]}}))), idle_o);
    end
    stop_test;
  end
endmodule // tb
